// file: sync_serial_status_irq.sv
// Status, flag and request logic of the synchronous serial port, APB slave.
// Assumes FIFO push/pop strobes and the shifter activity come from logic on clk.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "sync_serial_cfg.svh"

// Operation
// - Interrupt request follows its status bit unless masked by its enable or forced by test
// - Sticky bits: hardware sets, write one clears
// - Read-only flags ignore bus writes
// - Bit 2: transmit FIFO not full, resets one
// - Bit 3: receive FIFO holds any entry
// - Bit 4: busy while enabled and framing
// - Bit 5: enabled and transmit level at or below threshold
// - Transmit request gated by its enable
// - Bit 6: receive level at or above threshold
// - Receive request gated by its enable
// - Word into full receive FIFO dropped, overrun set
// - Overrun always requests; write one clears
// - Bits 15:12 receive count minus one
// - Bits 11:8 transmit count, full shows zero
// - Reserved status bits read zero, ignore writes
// - Test register bits force matching requests
// - Test register works while port disabled
// - Test bits 7 to 5 read/write, rest reserved
// - Enable masks request only, flag keeps working
// - FIFOs emptied on reset and while disabled
module sync_serial_status_irq #(
	parameter int DEPTH = `SSP_FIFO_DEPTH,
	parameter int CW = `SSP_COUNT_W
) (
	input wire logic clk, // 40 MHz system clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [`SSP_ADDR_W-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high for write
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic tx_write, // Software stores one word in transmit FIFO
	input wire logic tx_pop, // Shifter takes one word from transmit FIFO
	input wire logic rx_push, // Shifter delivers one received word
	input wire logic rx_read, // Software removes one word from receive FIFO
	input wire logic shifter_active, // A frame is being sent or received
	output logic tx_accepted, // Pulse: transmit word stored
	output logic rx_accepted, // Pulse: received word stored
	output logic rx_dropped, // Pulse: received word discarded on overrun
	output logic port_enable, // Port enable from control register
	output logic [`SSP_LEVEL_W-1:0] tx_level, // Transmit level as reported
	output logic [`SSP_LEVEL_W-1:0] rx_level, // Receive level as reported
	output logic irq_tx_service, // Transmit service request
	output logic irq_rx_service, // Receive service request
	output logic irq_rx_overrun // Receive overrun request
);
	sync_serial_pkg::port_ctrl_t ctrl;
	sync_serial_pkg::force_t force_req;
	logic rx_overrun;
	logic tx_service_req;
	logic rx_service_req;
	logic port_busy;
	logic tx_not_full;
	logic rx_not_empty;
	logic flush;
	logic wr_access;
	logic rd_setup;
	logic hit_ctrl;
	logic hit_status;
	logic hit_itest;
	logic addr_hit;
	logic ror_clear;
	logic next_rx_overrun;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic [31:0] itest_word;
	logic [31:0] next_prdata;

	fifo_level_if #(.CW(CW)) tx_lvl ();
	fifo_level_if #(.CW(CW)) rx_lvl ();

	// Threshold field holds the level minus one
	function automatic logic [CW-1:0] eff_threshold(input logic [`SSP_LEVEL_W-1:0] field);
		eff_threshold = CW'(field) + CW'(`SSP_COUNT_ONE);
	endfunction

	function automatic logic is_addr(input logic [`SSP_ADDR_W-1:0] a, input logic [`SSP_ADDR_W-1:0] off);
		is_addr = (a == off);
	endfunction

	// FIFO occupancy
	// Disabling the port holds both FIFOs empty, so levels return to reset values
	assign flush = !ctrl.port_enable;

	assign tx_lvl.push = tx_write;
	assign tx_lvl.pop = tx_pop;
	assign tx_lvl.flush = flush;
	assign rx_lvl.push = rx_push;
	assign rx_lvl.pop = rx_read;
	assign rx_lvl.flush = flush;

	fifo_level_counter #(
		.DEPTH(DEPTH),
		.CW(CW)
	) u_tx_count (
		.clk(clk),
		.rst_n(rst_n),
		.lvl(tx_lvl)
	);

	fifo_level_counter #(
		.DEPTH(DEPTH),
		.CW(CW)
	) u_rx_count (
		.clk(clk),
		.rst_n(rst_n),
		.lvl(rx_lvl)
	);

	assign tx_accepted = tx_lvl.accepted;
	assign rx_accepted = rx_lvl.accepted;
	assign rx_dropped = rx_lvl.dropped;

	// Flags, derived from FIFO and shifter state and from the control register
	assign tx_not_full = !tx_lvl.full;
	assign rx_not_empty = !rx_lvl.empty;
	assign port_busy = ctrl.port_enable && shifter_active;
	assign tx_service_req = ctrl.port_enable && (tx_lvl.count <= eff_threshold(ctrl.tx_threshold));
	assign rx_service_req = ctrl.port_enable && (rx_lvl.count >= eff_threshold(ctrl.rx_threshold));

	// A full transmit FIFO wraps to zero; empty receive wraps to all ones
	assign tx_level = tx_lvl.count[`SSP_LEVEL_W-1:0];
	assign rx_level = rx_lvl.count[`SSP_LEVEL_W-1:0] - `SSP_LEVEL_W'(`SSP_COUNT_ONE);

	assign port_enable = ctrl.port_enable;

	// Requests are combinational so they drop in the cycle the bit clears
	// Enables gate only the request; the flags above stay live
	assign irq_tx_service = (tx_service_req && ctrl.tx_irq_enable) || force_req.force_tx_service;
	assign irq_rx_service = (rx_service_req && ctrl.rx_irq_enable) || force_req.force_rx_service;
	assign irq_rx_overrun = rx_overrun || force_req.force_rx_overrun;

	// APB decode
	// Zero wait states: every transfer completes in its first access cycle
	assign pready = 1'b1;
	assign hit_ctrl = is_addr(paddr, `SSP_CTRL_OFF);
	assign hit_status = is_addr(paddr, `SSP_STATUS_OFF);
	assign hit_itest = is_addr(paddr, `SSP_ITEST_OFF);
	assign addr_hit = hit_ctrl || hit_status || hit_itest;
	assign pslverr = psel && penable && !addr_hit;
	assign wr_access = psel && penable && pwrite && addr_hit;
	assign rd_setup = psel && !penable && !pwrite;

	// Control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
		end else if (wr_access && hit_ctrl) begin
			ctrl.port_enable <= pwdata[`CT_EN];
			ctrl.rx_threshold <= pwdata[`CT_RFT_LSB +: `SSP_LEVEL_W];
			ctrl.tx_threshold <= pwdata[`CT_TFT_LSB +: `SSP_LEVEL_W];
			ctrl.tx_irq_enable <= pwdata[`CT_TIE];
			ctrl.rx_irq_enable <= pwdata[`CT_RIE];
		end
	end

	// Test register
	// Not gated by port_enable, so interrupt paths can be checked while disabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			force_req <= '0;
		end else if (wr_access && hit_itest) begin
			force_req.force_rx_overrun <= pwdata[`IT_FORCE_RX_OVERRUN];
			force_req.force_rx_service <= pwdata[`IT_FORCE_RX_SERVICE];
			force_req.force_tx_service <= pwdata[`IT_FORCE_TX_SERVICE];
		end
	end

	// Overrun sticky bit
	// A drop in the same cycle as a clear write wins, so no overrun goes unseen
	assign ror_clear = wr_access && hit_status && pwdata[`ST_ROR];
	assign next_rx_overrun = rx_lvl.dropped || (rx_overrun && !ror_clear);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_overrun <= 1'b0;
		end else begin
			rx_overrun <= next_rx_overrun;
		end
	end

	// Read words; only the overrun bit of the status word is writable
	always_comb begin
		status_word = `SSP_RESET_WORD;
		status_word[`ST_TNF] = tx_not_full;
		status_word[`ST_RNE] = rx_not_empty;
		status_word[`ST_BSY] = port_busy;
		status_word[`ST_TFS] = tx_service_req;
		status_word[`ST_RFS] = rx_service_req;
		status_word[`ST_ROR] = rx_overrun;
		status_word[`ST_TFL_LSB +: `SSP_LEVEL_W] = tx_level;
		status_word[`ST_RFL_LSB +: `SSP_LEVEL_W] = rx_level;
	end

	always_comb begin
		ctrl_word = `SSP_RESET_WORD;
		ctrl_word[`CT_EN] = ctrl.port_enable;
		ctrl_word[`CT_RFT_LSB +: `SSP_LEVEL_W] = ctrl.rx_threshold;
		ctrl_word[`CT_TFT_LSB +: `SSP_LEVEL_W] = ctrl.tx_threshold;
		ctrl_word[`CT_TIE] = ctrl.tx_irq_enable;
		ctrl_word[`CT_RIE] = ctrl.rx_irq_enable;
	end

	always_comb begin
		itest_word = `SSP_RESET_WORD;
		itest_word[`IT_FORCE_RX_OVERRUN] = force_req.force_rx_overrun;
		itest_word[`IT_FORCE_RX_SERVICE] = force_req.force_rx_service;
		itest_word[`IT_FORCE_TX_SERVICE] = force_req.force_tx_service;
	end

	always_comb begin
		next_prdata = `SSP_RESET_WORD;
		if (hit_ctrl) begin
			next_prdata = ctrl_word & `SSP_CTRL_MASK;
		end else if (hit_status) begin
			next_prdata = status_word;
		end else if (hit_itest) begin
			next_prdata = itest_word & `SSP_ITEST_MASK;
		end
	end

	// Read data is captured in the setup cycle and stands through the access cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= `SSP_RESET_WORD;
		end else if (rd_setup) begin
			prdata <= next_prdata;
		end
	end
endmodule

// file: sync_serial_cfg.svh
// Register offsets, field positions and reset values of the serial port status block.
// Included by the design files; holds definitions only.
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH

`define SSP_ADDR_W 12
`define SSP_CTRL_OFF 12'h004
`define SSP_STATUS_OFF 12'h008
`define SSP_ITEST_OFF 12'h00C

`define SSP_RESET_WORD 32'h0000_0000
`define SSP_CTRL_MASK 32'h0001_3FC3
`define SSP_ITEST_MASK 32'h0000_00E0

`define CT_RIE 0
`define CT_TIE 1
`define CT_TFT_LSB 6
`define CT_RFT_LSB 10
`define CT_EN 16

`define ST_TNF 2
`define ST_RNE 3
`define ST_BSY 4
`define ST_TFS 5
`define ST_RFS 6
`define ST_ROR 7
`define ST_TFL_LSB 8
`define ST_RFL_LSB 12

`define IT_FORCE_TX_SERVICE 5
`define IT_FORCE_RX_SERVICE 6
`define IT_FORCE_RX_OVERRUN 7

`define SSP_FIFO_DEPTH 16
`define SSP_LEVEL_W 4
`define SSP_COUNT_W 5
`define SSP_COUNT_ONE 5'h01

`endif

// file: sync_serial_pkg.sv
// Types shared by the serial port status block.
// Assumes sync_serial_cfg.svh for field widths.
`include "sync_serial_cfg.svh"

package sync_serial_pkg;
	typedef struct packed {
		logic port_enable;
		logic [`SSP_LEVEL_W-1:0] rx_threshold;
		logic [`SSP_LEVEL_W-1:0] tx_threshold;
		logic tx_irq_enable;
		logic rx_irq_enable;
	} port_ctrl_t;

	typedef struct packed {
		logic force_rx_overrun;
		logic force_rx_service;
		logic force_tx_service;
	} force_t;
endpackage

// file: fifo_level_if.sv
// Carrier between the status block and its FIFO occupancy counters.
// Assumes one clock; all signals change after the rising edge.
`timescale 1ns/100ps

interface fifo_level_if #(
	parameter int CW = 5
);
	logic push;
	logic pop;
	logic flush;
	logic accepted;
	logic dropped;
	logic full;
	logic empty;
	logic [CW-1:0] count;

	modport counter (
		input push,
		input pop,
		input flush,
		output accepted,
		output dropped,
		output full,
		output empty,
		output count
	);

	modport user (
		output push,
		output pop,
		output flush,
		input accepted,
		input dropped,
		input full,
		input empty,
		input count
	);
endinterface

// file: fifo_level_counter.sv
// Occupancy counter of one FIFO: counts valid entries, refuses pushes when full.
// Assumes push and pop come from logic on clk; flush holds the FIFO empty.
`timescale 1ns/100ps

module fifo_level_counter #(
	parameter int DEPTH = 16,
	parameter int CW = 5
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	fifo_level_if.counter lvl // Push, pop and level
);
	logic [CW-1:0] count;
	logic do_push;
	logic do_pop;

	// A push into a full FIFO is lost even when a pop comes in the same cycle
	assign lvl.full = (count == CW'(DEPTH));
	assign lvl.empty = (count == '0);
	assign do_pop = lvl.pop && !lvl.empty && !lvl.flush;
	assign do_push = lvl.push && !lvl.full && !lvl.flush;
	assign lvl.accepted = do_push;
	assign lvl.dropped = lvl.push && lvl.full && !lvl.flush;
	assign lvl.count = count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (lvl.flush) begin
			count <= '0;
		end else begin
			count <= count + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule

// file: ssp_far_model.sv
// Far side model: shifter and software strobes into the FIFOs.
// Assumes tasks are called from one bench process only.
`timescale 1ns/100ps
module ssp_far_model (
	input wire logic clk, // Clock
	output logic tx_write, // Store tx word
	output logic tx_pop, // Shifter takes tx word
	output logic rx_push, // Rx word arrives
	output logic rx_read, // Software reads rx word
	output logic shifter_active // Frame running
);
	logic [3:0] s = 4'h0;
	assign {rx_read, rx_push, tx_pop, tx_write} = s;
	initial shifter_active = 1'b0;
	// Back to back, one word a cycle, to hit the full boundary
	task automatic pulse(input int k, input int n);
		repeat (n) begin
			@(posedge clk);
			s <= 4'(1 << k);
		end
		@(posedge clk);
		s <= 4'h0;
	endtask
	task automatic busy(input logic v);
		@(posedge clk);
		shifter_active <= v;
	endtask
endmodule

// file: ssp_status_asserts.sv
// Checker of the serial port status block.
// Assumes one clock and rst_n asynchronous.
`timescale 1ns/100ps
module ssp_status_asserts (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Access
	input wire logic pwrite, // Write
	input wire logic tx_pop, // Tx pop
	input wire logic rx_push, // Rx push
	input wire logic rx_read, // Rx read
	input wire logic tx_accepted, // Tx stored
	input wire logic rx_accepted, // Rx stored
	input wire logic rx_dropped, // Rx lost
	input wire logic port_enable, // Enable
	input wire logic [3:0] tx_level, // Tx level
	input wire logic [3:0] rx_level, // Rx level
	input wire logic irq_rx_overrun // Overrun request
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	drop_sets_ovr_a: assert property (rx_dropped |=> irq_rx_overrun)
		else $error("overrun request missing");
	drop_full_a: assert property (rx_dropped |-> rx_level == 4'hF && port_enable)
		else $error("drop while not full");
	push_once_a: assert property (rx_push && port_enable |-> rx_accepted != rx_dropped)
		else $error("push neither stored nor dropped");
	dis_refuse_a: assert property (!port_enable |-> !tx_accepted && !rx_accepted && !rx_dropped)
		else $error("strobe taken while disabled");
	dis_empty_a: assert property (!port_enable [*2] |-> tx_level == 4'h0 && rx_level == 4'hF)
		else $error("levels not empty while disabled");
	tx_count_a: assert property (tx_accepted && !tx_pop |=> tx_level == $past(tx_level) + 4'h1)
		else $error("tx level not counted");
	rx_count_a: assert property (rx_accepted && !rx_read |=> rx_level == $past(rx_level) + 4'h1)
		else $error("rx level not counted");
	ovr_sticky_a: assert property (irq_rx_overrun && !(psel && penable && pwrite) |=> irq_rx_overrun)
		else $error("overrun lost without write");
	drop_c: cover property (rx_dropped);
	clr_c: cover property ($fell(irq_rx_overrun));
	full_c: cover property (tx_accepted && tx_level == 4'hF);
endmodule
bind sync_serial_status_irq ssp_status_asserts i_chk(.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .tx_pop(tx_pop), .rx_push(rx_push), .rx_read(rx_read),
	.tx_accepted(tx_accepted), .rx_accepted(rx_accepted), .rx_dropped(rx_dropped),
	.port_enable(port_enable), .tx_level(tx_level), .rx_level(rx_level), .irq_rx_overrun(irq_rx_overrun));

// file: sync_serial_status_irq_tb_top.sv
// Self-checking bench of the serial port status block.
// Assumes the far side model drives the FIFO strobes.
`timescale 1ns/100ps
`include "sync_serial_cfg.svh"
module sync_serial_status_irq_tb_top;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic tw, tp, rp, rr, act, it, ir, io;
	int errors, compares;
	sync_serial_status_irq i_dut(.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_write(tw), .tx_pop(tp), .rx_push(rp), .rx_read(rr), .shifter_active(act), .tx_accepted(),
		.rx_accepted(), .rx_dropped(), .port_enable(), .tx_level(), .rx_level(),
		.irq_tx_service(it), .irq_rx_service(ir), .irq_rx_overrun(io));
	ssp_far_model i_far(.clk(clk), .tx_write(tw), .tx_pop(tp), .rx_push(rp), .rx_read(rr),
		.shifter_active(act));
	task automatic chk(input logic [31:0] g, x);
		compares++;
		if (g !== x) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, x);
	endtask
	task automatic ck(input logic [2:0] x);
		repeat (2) @(posedge clk);
		// Look mid-cycle, where the combinational requests have settled
		@(negedge clk);
		chk({29'h0, io, ir, it}, {29'h0, x});
	endtask
	task automatic results;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic t_regs;
		rd(`SSP_STATUS_OFF, 32'h0000_F004);
		rd(`SSP_ITEST_OFF, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk(32'(e), 32'h0000_0001);
		apb(1'b1, `SSP_ITEST_OFF, 32'hFFFF_FFFF);
		rd(`SSP_ITEST_OFF, 32'h0000_00E0);
		ck(3'b111);
		apb(1'b1, `SSP_ITEST_OFF, 32'h0000_0000);
		ck(3'b000);
		$display("register test done");
	endtask
	task automatic t_tx;
		apb(1'b1, `SSP_CTRL_OFF, 32'h0001_0843);
		ck(3'b001);
		i_far.pulse(0, 3);
		ck(3'b000);
		rd(`SSP_STATUS_OFF, 32'h0000_F304);
		apb(1'b1, `SSP_STATUS_OFF, 32'hFFFF_FF7F);
		rd(`SSP_STATUS_OFF, 32'h0000_F304);
		i_far.pulse(0, 14);
		rd(`SSP_STATUS_OFF, 32'h0000_F000);
		i_far.pulse(1, 1);
		rd(`SSP_STATUS_OFF, 32'h0000_FF04);
		$display("transmit test done");
	endtask
	task automatic t_rx;
		i_far.pulse(2, 3);
		ck(3'b010);
		apb(1'b1, `SSP_CTRL_OFF, 32'h0001_0842);
		ck(3'b000);
		rd(`SSP_STATUS_OFF, 32'h0000_2F4C);
		i_far.pulse(2, 14);
		ck(3'b100);
		rd(`SSP_STATUS_OFF, 32'h0000_FFCC);
		apb(1'b1, `SSP_STATUS_OFF, 32'h0000_0000);
		ck(3'b100);
		i_far.pulse(3, 16);
		apb(1'b1, `SSP_STATUS_OFF, 32'h0000_0080);
		ck(3'b000);
		$display("receive test done");
	endtask
	task automatic t_busy;
		i_far.busy(1'b1);
		rd(`SSP_STATUS_OFF, 32'h0000_FF14);
		apb(1'b1, `SSP_CTRL_OFF, 32'h0000_0000);
		rd(`SSP_STATUS_OFF, 32'h0000_F004);
		ck(3'b000);
		i_far.busy(1'b0);
		$display("busy test done");
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_tx();
		t_rx();
		t_busy();
		results();
	end
	// Tests need about 150 cycles
	initial begin
		#200000;
		errors++;
		results();
	end
endmodule
